// File: ulpi_lp_regs.svh
// constants for the ulpi low power control pair
`ifndef ULPI_LP_REGS_SVH
`define ULPI_LP_REGS_SVH
// ulpi register map seen by the link
`define FUNC_CTRL_ADDR 6'h04
`define SUSPEND_BIT 6
`define IFACE_CTRL_ADDR 6'h07
`define PULLUP_DIS_BIT 7
`define INT_RISE_ADDR 6'h0d
`define INT_FALL_ADDR 6'h10
`define INT_EN_LSB 1
`define HS_COMP_ADDR 6'h31
`define FAST_WAKE_BIT 0
`define REG_WRITE_CMD 2'b10
// timing
`define SYS_CLK_NS 5
`define IFCLK_HALF_CYCLES 2'd2
`define MIN_CLK_EDGES 3'd5
`define T_START_NS 2000
`define T_START_FAST_NS 500
`define T_START_CYCLES 12'((`T_START_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define T_START_FAST_CYCLES 12'((`T_START_FAST_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
// link control port map
`define LINK_ADDR_REG 2'd0
`define LINK_DATA_REG 2'd1
`define LINK_CTRL_REG 2'd2
`define LINK_GO_BIT 0
`define LINK_WAKE_BIT 1
`endif

// File: ulpi_lp_pkg.sv
// state types for the ulpi low power control pair
package ulpi_lp_pkg;
  typedef enum logic [2:0] {
    PHY_SYNC = 3'b000,
    PHY_ENTER = 3'b001,
    PHY_LOWPWR = 3'b011,
    PHY_STARTUP = 3'b010,
    PHY_RESTART = 3'b110,
    PHY_RELEASE = 3'b100
  } phy_state_e;
  typedef enum logic [2:0] {
    LINK_INIT = 3'b000,
    LINK_IDLE = 3'b001,
    LINK_CMD = 3'b011,
    LINK_DATA = 3'b010,
    LINK_STOP = 3'b110,
    LINK_WAKE = 3'b100
  } link_state_e;
endpackage

// File: ulpi_lp_if.sv
// ulpi pins between transceiver and link, with wire resolution
`timescale 1ns/100ps
interface ulpi_lp_if;
  logic ulpi_clk;
  logic dir;
  logic nxt;
  logic stp_o;
  logic stp_oe;
  logic stp_pullup_en;
  logic [7:0] dat_phy;
  logic dat_phy_oe;
  logic [7:0] dat_link;
  logic dat_link_oe;
  wire stp;
  wire [7:0] dat;
  // undriven stp follows the pull-up, undriven data follows the weak pull-downs
  assign stp = stp_oe ? stp_o : stp_pullup_en;
  assign dat = dat_phy_oe ? dat_phy : (dat_link_oe ? dat_link : 8'h00);
  modport phy (
    output ulpi_clk, dir, nxt, stp_pullup_en, dat_phy, dat_phy_oe,
    input stp, dat
  );
  modport link (
    output stp_o, stp_oe, dat_link, dat_link_oe,
    input ulpi_clk, dir, nxt, stp, dat
  );
endinterface

// File: ulpi_lp_phy.sv
// transceiver end: suspend entry, low power data remap and wake-up
// Notes on behaviour
// - link clears suspend bit by register write
// - dir high, stop clock after five edges
// - power down only once clock stopped
// - data0 follows dp, data1 follows dm
// - data2 and data7..4 driven low
// - data3 is active-high interrupt
// - enabled comparator changes raise interrupt
// - remapped bus driven without interface clock
// - stp high starts power-up
// - restart clock, then drop dir
// - link holds stp until dir low
// - suspend bit returns to one on exit
// - early stp release means false resume
// - link sets fast wake for power management
// - bus always driven, one-cycle turnaround; after dir falls the bus stays undriven for two interface clock cycles
// - unready link holds stp before dir drops
// - link drives idle after turnaround
// - stp pull-up on at reset, bit disables
// - link resets with stp high, data released
// - link holds stp low during low power
// - any stp high wakes from low power; here stp released before start-up ends sends the phy back to low power
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "ulpi_lp_regs.svh"
module ulpi_lp_phy (
  input wire logic sys_clk,
  input wire logic reset_n,
  ulpi_lp_if.phy u,
  input wire logic vbus_valid_cmp,
  input wire logic session_valid_cmp,
  input wire logic session_end_cmp,
  input wire logic id_ground_cmp,
  input wire logic dp_rx,
  input wire logic dm_rx,
  output logic low_power,
  output logic suspend_control_bit,
  output logic stop_pullup_disable,
  output logic fast_wake_enable
);
  ulpi_lp_pkg::phy_state_e state;
  logic [1:0] div_cnt;
  logic ifclk;
  logic ifclk_q;
  logic clk_run;
  logic rise;
  logic [1:0] phase;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_stb;
  logic [2:0] edge_cnt;
  logic [11:0] start_cnt;
  logic [3:0] cmp;
  logic [3:0] snap;
  logic [3:0] en_rise;
  logic [3:0] en_fall;
  logic irq;
  logic enter_req;
  logic exit_done;
  logic remap;

  // ==========================================================
  // interface clock
  assign cmp = {id_ground_cmp, session_end_cmp, session_valid_cmp, vbus_valid_cmp};
  assign u.ulpi_clk = ifclk;
  // both ends act one system cycle after the clock rises, seeing values from before it
  assign rise = ifclk & ~ifclk_q;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      div_cnt <= 2'd0;
      ifclk <= 1'b0;
      ifclk_q <= 1'b0;
    end
    else
    begin
      ifclk_q <= ifclk;
      if (div_cnt == `IFCLK_HALF_CYCLES - 2'd1)
      begin
        div_cnt <= 2'd0;
        // a stopped clock completes its high phase and then rests low
        if (clk_run || ifclk)
          ifclk <= ~ifclk;
      end
      else
        div_cnt <= div_cnt + 2'd1;
    end

  // ==========================================================
  // ulpi register writes
  assign wr_stb = rise && (state == ulpi_lp_pkg::PHY_SYNC) && (phase == 2'd3) && u.stp;
  assign enter_req = wr_stb && (wr_addr == `FUNC_CTRL_ADDR) && !wr_data[`SUSPEND_BIT];
  assign exit_done = rise && (state == ulpi_lp_pkg::PHY_RESTART) && u.stp;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      phase <= 2'd0;
      wr_addr <= 6'h00;
      wr_data <= 8'h00;
      u.nxt <= 1'b0;
    end
    else if (rise && state == ulpi_lp_pkg::PHY_SYNC)
    begin
      case (phase)
        2'd0:
          if (u.dat[7:6] == `REG_WRITE_CMD)
          begin
            wr_addr <= u.dat[5:0];
            u.nxt <= 1'b1;
            phase <= 2'd1;
          end
        2'd1:
        begin
          u.nxt <= 1'b0;
          phase <= 2'd2;
        end
        2'd2:
        begin
          wr_data <= u.dat;
          phase <= 2'd3;
        end
        default:
          phase <= 2'd0;
      endcase
    end

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      suspend_control_bit <= 1'b1;
      stop_pullup_disable <= 1'b0;
      en_rise <= 4'h0;
      en_fall <= 4'h0;
      fast_wake_enable <= 1'b0;
    end
    else if (exit_done)
      suspend_control_bit <= 1'b1;
    else if (wr_stb)
    begin
      if (wr_addr == `FUNC_CTRL_ADDR)
        suspend_control_bit <= wr_data[`SUSPEND_BIT];
      else if (wr_addr == `IFACE_CTRL_ADDR)
        stop_pullup_disable <= wr_data[`PULLUP_DIS_BIT];
      else if (wr_addr == `INT_RISE_ADDR)
        en_rise <= wr_data[`INT_EN_LSB +: 4];
      else if (wr_addr == `INT_FALL_ADDR)
        en_fall <= wr_data[`INT_EN_LSB +: 4];
      else if (wr_addr == `HS_COMP_ADDR)
        fast_wake_enable <= wr_data[`FAST_WAKE_BIT];
    end

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      u.stp_pullup_en <= 1'b1;
    else
      u.stp_pullup_en <= ~stop_pullup_disable;

  // ==========================================================
  // low power sequence
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      state <= ulpi_lp_pkg::PHY_SYNC;
      u.dir <= 1'b0;
      clk_run <= 1'b1;
      edge_cnt <= 3'd0;
      start_cnt <= 12'd0;
    end
    else
    begin
      case (state)
        ulpi_lp_pkg::PHY_SYNC:
          if (enter_req)
          begin
            u.dir <= 1'b1;
            edge_cnt <= 3'd0;
            state <= ulpi_lp_pkg::PHY_ENTER;
          end
        ulpi_lp_pkg::PHY_ENTER:
        begin
          if (rise)
          begin
            edge_cnt <= edge_cnt + 3'd1;
            if (edge_cnt == `MIN_CLK_EDGES - 3'd1)
              clk_run <= 1'b0;
          end
          if (!clk_run && !ifclk)
            state <= ulpi_lp_pkg::PHY_LOWPWR;
        end
        ulpi_lp_pkg::PHY_LOWPWR:
          // clock is stopped here; stp is watched on the free system clock
          if (u.stp)
          begin
            start_cnt <= fast_wake_enable ? `T_START_FAST_CYCLES : `T_START_CYCLES;
            state <= ulpi_lp_pkg::PHY_STARTUP;
          end
        ulpi_lp_pkg::PHY_STARTUP:
          if (!u.stp)
            state <= ulpi_lp_pkg::PHY_LOWPWR;
          else if (start_cnt == 12'd0)
          begin
            clk_run <= 1'b1;
            state <= ulpi_lp_pkg::PHY_RESTART;
          end
          else
            start_cnt <= start_cnt - 12'd1;
        ulpi_lp_pkg::PHY_RESTART:
          if (!u.stp)
          begin
            clk_run <= 1'b0;
            state <= ulpi_lp_pkg::PHY_ENTER;
          end
          else if (rise)
          begin
            u.dir <= 1'b0;
            state <= ulpi_lp_pkg::PHY_RELEASE;
          end
        default:
          // commands are not decoded until the link lets go of stp
          if (rise && !u.stp)
            state <= ulpi_lp_pkg::PHY_SYNC;
      endcase
    end

  assign remap = (state == ulpi_lp_pkg::PHY_LOWPWR) || (state == ulpi_lp_pkg::PHY_STARTUP)
    || (state == ulpi_lp_pkg::PHY_RESTART);

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      low_power <= 1'b0;
    else
      low_power <= (state == ulpi_lp_pkg::PHY_LOWPWR) || (state == ulpi_lp_pkg::PHY_STARTUP);

  // ==========================================================
  // comparator interrupt
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      snap <= 4'h0;
      irq <= 1'b0;
    end
    else if (state == ulpi_lp_pkg::PHY_SYNC)
    begin
      snap <= cmp;
      irq <= 1'b0;
    end
    else if (remap)
      irq <= irq | (|((cmp & ~snap & en_rise) | (~cmp & snap & en_fall)));

  // ==========================================================
  // data bus
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      u.dat_phy <= 8'h00;
      u.dat_phy_oe <= 1'b0;
    end
    else
    begin
      // refreshed every system cycle, independent of the stopped clock
      if (remap)
        u.dat_phy <= {4'h0, irq, 1'b0, dm_rx, dp_rx};
      else
        u.dat_phy <= 8'h00;
      // phy takes the bus two edges after raising dir, leaves with dir
      if (state == ulpi_lp_pkg::PHY_ENTER && rise && edge_cnt != 3'd0)
        u.dat_phy_oe <= 1'b1;
      else if (state == ulpi_lp_pkg::PHY_RESTART && rise && u.stp)
        u.dat_phy_oe <= 1'b0;
    end
endmodule

// File: ulpi_lp_link.sv
// link end: register writes over ulpi, suspend request and wake-up
`timescale 1ns/100ps
`include "ulpi_lp_regs.svh"
module ulpi_lp_link (
  input wire logic sys_clk,
  input wire logic reset_n,
  ulpi_lp_if.link u,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  ulpi_lp_pkg::link_state_e state;
  logic clk_q;
  logic rise;
  logic dir_q;
  logic [5:0] ulpi_addr;
  logic [7:0] ulpi_data;
  logic go;
  logic wake;

  assign rise = u.ulpi_clk & ~clk_q;

  // ==========================================================
  // control port
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      ulpi_addr <= 6'h00;
      ulpi_data <= 8'h00;
      rdata <= 8'h00;
    end
    else
    begin
      if (wr && addr == `LINK_ADDR_REG)
        ulpi_addr <= wdata[5:0];
      if (wr && addr == `LINK_DATA_REG)
        ulpi_data <= wdata;
      if (rd)
      begin
        if (addr == `LINK_ADDR_REG)
          rdata <= {2'b00, ulpi_addr};
        else if (addr == `LINK_DATA_REG)
          rdata <= ulpi_data;
        else if (addr == `LINK_CTRL_REG)
          rdata <= {5'h00, u.stp, state != ulpi_lp_pkg::LINK_IDLE, u.dir};
        else
          rdata <= 8'h00;
      end
    end

  // requests last only the write cycle; one that comes while the sequencer is not idle is lost
  assign go = wr && addr == `LINK_CTRL_REG && wdata[`LINK_GO_BIT];
  assign wake = wr && addr == `LINK_CTRL_REG && wdata[`LINK_WAKE_BIT];

  // ==========================================================
  // sequencer
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      state <= ulpi_lp_pkg::LINK_INIT;
      clk_q <= 1'b0;
      dir_q <= 1'b0;
      u.stp_o <= 1'b1;
      u.stp_oe <= 1'b1;
      u.dat_link <= 8'h00;
      u.dat_link_oe <= 1'b0;
    end
    else
    begin
      clk_q <= u.ulpi_clk;
      if (rise)
      begin
        dir_q <= u.dir;
        u.dat_link_oe <= !u.dir && !dir_q;
      end
      case (state)
        ulpi_lp_pkg::LINK_INIT:
          // stp stays high until the phy is seen running with dir low
          if (rise && !u.dir)
          begin
            u.stp_o <= 1'b0;
            state <= ulpi_lp_pkg::LINK_IDLE;
          end
        ulpi_lp_pkg::LINK_IDLE:
          if (wake && u.dir)
          begin
            u.stp_o <= 1'b1;
            state <= ulpi_lp_pkg::LINK_WAKE;
          end
          else if (go && !u.dir)
          begin
            u.dat_link <= {`REG_WRITE_CMD, ulpi_addr};
            state <= ulpi_lp_pkg::LINK_CMD;
          end
          else
            u.stp_o <= 1'b0;
        ulpi_lp_pkg::LINK_CMD:
          if (rise && u.nxt)
          begin
            u.dat_link <= ulpi_data;
            state <= ulpi_lp_pkg::LINK_DATA;
          end
        ulpi_lp_pkg::LINK_DATA:
          if (rise)
          begin
            u.stp_o <= 1'b1;
            u.dat_link <= 8'h00;
            state <= ulpi_lp_pkg::LINK_STOP;
          end
        ulpi_lp_pkg::LINK_STOP:
          if (rise)
          begin
            u.stp_o <= 1'b0;
            state <= ulpi_lp_pkg::LINK_IDLE;
          end
        default:
          if (rise && !u.dir)
          begin
            u.stp_o <= 1'b0;
            state <= ulpi_lp_pkg::LINK_IDLE;
          end
      endcase
    end
endmodule

// File: ulpi_lp_props.sv
// concurrent checks on the ulpi pins between transceiver and link
`timescale 1ns/100ps
module ulpi_lp_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ulpi_clk,
  input wire logic dir,
  input wire logic stp,
  input wire logic [7:0] dat,
  input wire logic dat_phy_oe,
  input wire logic dat_link_oe,
  input wire logic stp_pullup_en,
  input wire logic low_power,
  input wire logic suspend_control_bit,
  input wire logic stop_pullup_disable,
  input wire logic dp_rx,
  input wire logic dm_rx
);
  // start-up count plus one restart edge, with margin
  localparam int wake_max = 500;
  logic clk_q;
  logic [3:0] rise_cnt;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // ====
  // interface clock rises seen since dir went high, saturating
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_q <= 1'b0;
      rise_cnt <= 4'h0;
    end
    else
    begin
      clk_q <= ulpi_clk;
      if (!dir)
        rise_cnt <= 4'h0;
      else if (ulpi_clk && !clk_q && rise_cnt != 4'hf)
        rise_cnt <= rise_cnt + 4'h1;
    end
  end
  // ====
  // properties
  sequence s_wake_req;
    low_power && $rose(stp);
  endsequence
  sequence s_wake_end;
    !low_power || !stp;
  endsequence
  sequence s_dir_drop;
    $fell(dir);
  endsequence
  property p_one_driver;
    !(dat_phy_oe && dat_link_oe);
  endproperty
  property p_phy_owns;
    dat_phy_oe |-> dir;
  endproperty
  property p_five_edges;
    $rose(low_power) |-> rise_cnt >= 4'h5;
  endproperty
  property p_clk_stopped;
    $rose(low_power) |-> (!ulpi_clk) [*8];
  endproperty
  property p_lp_driven;
    low_power |-> dir && dat_phy_oe;
  endproperty
  property p_reserved_low;
    low_power |-> dat[7:4] == 4'h0 && !dat[2];
  endproperty
  property p_linestate;
    low_power && $stable(dp_rx) && $stable(dm_rx) |-> dat[1:0] == {dm_rx, dp_rx};
  endproperty
  property p_wake;
    s_wake_req |-> ##[1:wake_max] s_wake_end;
  endproperty
  property p_restart_first;
    s_dir_drop |-> ulpi_clk && !low_power;
  endproperty
  property p_suspend_back;
    s_dir_drop |-> ##[0:2] suspend_control_bit;
  endproperty
  property p_pullup_off;
    stop_pullup_disable |-> ##[0:2] !stp_pullup_en;
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("data bus driven by both ends");
  a_phy_owns: assert property (p_phy_owns) else $error("phy drives bus with dir low");
  a_five_edges: assert property (p_five_edges) else $error("clock stopped too early");
  a_clk_stopped: assert property (p_clk_stopped) else $error("clock runs in low power");
  a_lp_driven: assert property (p_lp_driven) else $error("bus not driven in low power");
  a_reserved_low: assert property (p_reserved_low) else $error("reserved bits not low");
  a_linestate: assert property (p_linestate) else $error("linestate does not follow dp dm");
  a_wake: assert property (p_wake) else $error("no wake after stp");
  a_restart_first: assert property (p_restart_first) else $error("dir dropped before clock");
  a_suspend_back: assert property (p_suspend_back) else $error("suspend bit not restored");
  a_pullup_off: assert property (p_pullup_off) else $error("stp pull-up still on");
endmodule

// File: test_ulpi_low_power_control.sv
// self-checking bench for the ulpi low power control pair
`timescale 1ns/100ps
`include "ulpi_lp_regs.svh"
module test_ulpi_low_power_control;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic vbus_valid_cmp = 1'b0;
  logic session_valid_cmp = 1'b0;
  logic session_end_cmp = 1'b0;
  logic id_ground_cmp = 1'b1;
  logic dp_rx = 1'b1;
  logic dm_rx = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic low_power;
  logic suspend_control_bit;
  logic stop_pullup_disable;
  logic fast_wake_enable;
  int mismatches = 0;
  int num_checks = 0;
  int n_slow;
  int n_fast;
  always #2.5 sys_clk = ~sys_clk;
  ulpi_lp_if u_ulpi_lp_if ();
  ulpi_lp_phy u_ulpi_lp_phy (.sys_clk(sys_clk), .reset_n(reset_n), .u(u_ulpi_lp_if),
    .vbus_valid_cmp(vbus_valid_cmp), .session_valid_cmp(session_valid_cmp),
    .session_end_cmp(session_end_cmp), .id_ground_cmp(id_ground_cmp), .dp_rx(dp_rx),
    .dm_rx(dm_rx), .low_power(low_power), .suspend_control_bit(suspend_control_bit),
    .stop_pullup_disable(stop_pullup_disable), .fast_wake_enable(fast_wake_enable));
  ulpi_lp_link u_ulpi_lp_link (.sys_clk(sys_clk), .reset_n(reset_n), .u(u_ulpi_lp_if),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ulpi_lp_props chk (.sys_clk(sys_clk), .reset_n(reset_n), .ulpi_clk(u_ulpi_lp_if.ulpi_clk),
    .dir(u_ulpi_lp_if.dir), .stp(u_ulpi_lp_if.stp), .dat(u_ulpi_lp_if.dat),
    .dat_phy_oe(u_ulpi_lp_if.dat_phy_oe), .dat_link_oe(u_ulpi_lp_if.dat_link_oe),
    .stp_pullup_en(u_ulpi_lp_if.stp_pullup_en), .low_power(low_power),
    .suspend_control_bit(suspend_control_bit), .stop_pullup_disable(stop_pullup_disable),
    .dp_rx(dp_rx), .dm_rx(dm_rx));
  // ====
  // report and compare
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic expire(input string name);
    mismatches++;
    $display("ERROR %s expected done seen timeout", name);
    test_done();
  endtask
  // ====
  // control port cycles
  task automatic port_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic port_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    int n;
    s = 8'hff;
    n = 0;
    while (s[1] !== 1'b0)
    begin
      port_rd(2'd2, s);
      n++;
      if (n > 100)
        expire("link_busy");
    end
  endtask
  task automatic ulpi_wr(input logic [5:0] ra, input logic [7:0] d);
    port_wr(2'd0, {2'b00, ra});
    port_wr(2'd1, d);
    port_wr(2'd2, 8'h01);
    wait_idle();
  endtask
  task automatic enter_lp;
    int n;
    ulpi_wr(`FUNC_CTRL_ADDR, 8'h00);
    n = 0;
    while (low_power !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 200)
        expire("low_power");
    end
    check8("dir", 8'h01, {7'h0, u_ulpi_lp_if.dir});
    check8("ulpi_clk", 8'h00, {7'h0, u_ulpi_lp_if.ulpi_clk});
    check8("suspend_bit", 8'h00, {7'h0, suspend_control_bit});
    check8("stp_lp", 8'h00, {7'h0, u_ulpi_lp_if.stp});
  endtask
  task automatic leave_lp(output int n);
    // the wake strobe only makes the link raise stp; the timing is all the phy's
    port_wr(2'd2, 8'h02);
    n = 0;
    while (u_ulpi_lp_if.dir !== 1'b0)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 1000)
        expire("wake");
    end
    check8("low_power", 8'h00, {7'h0, low_power});
    check8("suspend_bit", 8'h01, {7'h0, suspend_control_bit});
    wait_idle();
    repeat (8) @(posedge sys_clk);
    #1;
    check8("stp", 8'h00, {7'h0, u_ulpi_lp_if.stp});
    check8("link_drive", 8'h01, {7'h0, u_ulpi_lp_if.dat_link_oe});
  endtask
  task automatic settle_irq(input logic exp);
    repeat (8) @(posedge sys_clk);
    #1;
    check8("irq", {7'h0, exp}, {7'h0, u_ulpi_lp_if.dat[3]});
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    check8("suspend_bit", 8'h01, {7'h0, suspend_control_bit});
    check8("pullup_dis", 8'h00, {7'h0, stop_pullup_disable});
    check8("pullup_en", 8'h01, {7'h0, u_ulpi_lp_if.stp_pullup_en});
    check8("fast_wake", 8'h00, {7'h0, fast_wake_enable});
  endtask
  task automatic t_pullup;
    ulpi_wr(`IFACE_CTRL_ADDR, 8'h80);
    check8("pullup_dis", 8'h01, {7'h0, stop_pullup_disable});
    check8("pullup_en", 8'h00, {7'h0, u_ulpi_lp_if.stp_pullup_en});
  endtask
  task automatic t_slow;
    ulpi_wr(`INT_RISE_ADDR, 8'h02);
    enter_lp();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      dp_rx <= i[0];
      dm_rx <= i[1];
      repeat (3) @(posedge sys_clk);
      #1;
      check8("lp_bus", 8'(i), u_ulpi_lp_if.dat);
    end
    @(posedge sys_clk);
    session_valid_cmp <= 1'b1;
    settle_irq(1'b0);
    @(posedge sys_clk);
    vbus_valid_cmp <= 1'b1;
    settle_irq(1'b1);
    leave_lp(n_slow);
    check8("slow_wake", 8'h01, {7'h0, n_slow >= int'(`T_START_CYCLES)});
  endtask
  task automatic t_fast;
    ulpi_wr(`HS_COMP_ADDR, 8'h01);
    check8("fast_wake", 8'h01, {7'h0, fast_wake_enable});
    ulpi_wr(`INT_RISE_ADDR, 8'h00);
    ulpi_wr(`INT_FALL_ADDR, 8'h10);
    enter_lp();
    settle_irq(1'b0);
    @(posedge sys_clk);
    id_ground_cmp <= 1'b0;
    settle_irq(1'b1);
    leave_lp(n_fast);
    check8("fast_min", 8'h01, {7'h0, n_fast >= int'(`T_START_FAST_CYCLES)});
    check8("fast_lt_slow", 8'h01, {7'h0, n_fast < n_slow});
  endtask
  // ====
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    t_reset();
    t_pullup();
    t_slow();
    t_fast();
    test_done();
  end
endmodule
